// >>> lsn_negotiator.sv
// Start-up negotiation of protocol version and management channel rates for one link port
//
// Contract
// R1 - Master entering protocol setup sends its highest available protocol version.
// R2 - Master: received version equal to sent version completes protocol setup.
// R3 - Master on mismatch sends highest available version not above received, else lowest.
// R4 - Slave decodes received version; on mismatch reselects highest not above, else lowest.
// R5 - Slave completes protocol setup when received equals currently sent version.
// R6 - Protocol setup reads only sync, hyperframe number and version bytes.
// R7 - Filtered layer one control bits are used only from rate setup onward.
// R8 - Master entering rate setup sends highest available HDLC and Ethernet rates.
// R9 - Rate setup completes when at least one received rate equals sent rate.
// R10 - Master with both rates differing reselects each as highest not above received.
// R11 - Reselection giving zero rate sends lowest available rate instead.
// R12 - Slave with both rates differing reselects both rates the same way.
// R13 - Master may propose custom HDLC code only when custom channel is known.
// R14 - Slave echoes received custom HDLC code when it knows the custom channel.
// R15 - In rate setup and interface negotiation, version mismatch returns to protocol setup.
// R16 - In interface negotiation, both rates differing returns to rate setup.
// R17 - Use Ethernet channel if an Ethernet rate was agreed, else HDLC.
// R18 - After custom HDLC negotiation, send the custom HDLC code.
// R19 - Clear start-up timer once higher-layer management connection is up.
// R20 - Master with no new version before timer expiry flags no common version.
// R21 - Rate setup interprets layer one inband protocol, possibly entering passive link.
// R22 - Evaluate received bytes every 0.1 s and update transmit values promptly.
// R23 - Send zero in reserved bits and ignore them on receive.
// R24 - Master requesting no management channel enters passive link and clears timer.
// R25 - Hold received values; reselect only when first valid or changed.
`timescale 1ns/100ps
`default_nettype none
`include "lsn_params.svh"

module lsn_negotiator
	import lsn_pkg::*;
#(
	parameter int unsigned EVAL_CYCLES    = (`LSN_CLK_HZ / 1000) * `LSN_EVAL_PERIOD_MS,
	parameter int unsigned STARTUP_CYCLES = (`LSN_CLK_HZ / 1000) * `LSN_STARTUP_MS
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            hyperframe_sync_state,
	input  wire lsn_ctrl_bytes_t rx_bytes,
	input  wire logic            layer_one_passive,
	output lsn_ctrl_bytes_t      tx_bytes,
	output lsn_state_t           link_state,
	output logic                 use_eth,
	output logic                 use_hdlc,
	output logic                 startup_timer_running,
	output logic                 restart_pulse
);

	// Highest value of the range not above want, else the lowest of the range
	function automatic logic [7:0] lsn_pick(input logic [7:0] want, input lsn_range_t r);
		logic [7:0] res;
		res = r.lo;
		if (want >= r.hi) begin
			res = r.hi;
		end else if (want >= r.lo) begin
			res = want;
		end
		return res;
	endfunction : lsn_pick

	// Rate pick where a zero result means no link and falls back to the lowest rate
	function automatic logic [7:0] lsn_pick_rate(input logic [7:0] want, input lsn_range_t r);
		logic [7:0] res;
		res = lsn_pick(want, r);
		if (res == 8'h00) begin
			res = r.lo;
		end
		return res;
	endfunction : lsn_pick_rate

	// Register state
	logic [`LSN_CTRL_BITS-1:0] ctrl, next_ctrl;
	lsn_range_t                proto_range, next_proto_range;
	lsn_range_t                hdlc_range, next_hdlc_range;
	lsn_range_t                eth_range, next_eth_range;
	logic                      expired, next_expired;
	logic                      no_common, next_no_common;
	logic [31:0]               next_prdata;
	logic                      next_pready;
	logic                      next_pslverr;

	// Negotiation state
	lsn_state_t                next_link_state;
	lsn_ctrl_bytes_t           next_tx_bytes;
	lsn_ctrl_bytes_t           held, next_held;
	logic                      held_valid, next_held_valid;
	logic [31:0]               eval_cnt, next_eval_cnt;
	logic [31:0]               timer_cnt, next_timer_cnt;
	logic                      next_timer_running;
	logic                      next_use_eth;
	logic                      next_use_hdlc;
	logic                      next_restart_pulse;

	logic                      apb_access;
	logic                      apb_wr;
	logic                      is_master;
	logic                      eval_tick;
	logic                      timer_expiry;
	lsn_ctrl_bytes_t           rx_clean;

	assign apb_access = psel && penable && !pready;
	assign apb_wr     = apb_access && pwrite;
	assign is_master  = ctrl[`LSN_CTRL_MASTER];
	assign eval_tick  = (eval_cnt == 32'(EVAL_CYCLES - 1)); // R22
	assign timer_expiry = startup_timer_running && (timer_cnt == 32'(STARTUP_CYCLES - 1));

	// Reserved bits of the rate bytes are dropped before any compare
	always_comb begin
		rx_clean.proto = rx_bytes.proto;
		rx_clean.hdlc  = rx_bytes.hdlc & `LSN_HDLC_MASK; // R23
		rx_clean.eth   = rx_bytes.eth & `LSN_ETH_MASK; // R23
	end

	// APB slave: one wait state, so pready and prdata come from flops
	always_comb begin
		next_ctrl        = ctrl;
		next_proto_range = proto_range;
		next_hdlc_range  = hdlc_range;
		next_eth_range   = eth_range;
		next_pready      = apb_access;
		next_pslverr     = 1'b0;
		next_prdata      = 32'h0000_0000;
		if (apb_access) begin
			unique case (paddr)
				`LSN_OFF_CTRL: begin
					next_prdata = {24'h00_0000, ctrl};
					if (pwrite) begin
						next_ctrl = pwdata[`LSN_CTRL_BITS-1:0];
					end
				end
				`LSN_OFF_PROTO_RANGE: begin
					next_prdata = {16'h0000, proto_range};
					if (pwrite) begin
						next_proto_range = pwdata[15:0];
					end
				end
				`LSN_OFF_HDLC_RANGE: begin
					next_prdata = {16'h0000, hdlc_range};
					if (pwrite) begin
						next_hdlc_range = pwdata[15:0] & {`LSN_HDLC_MASK, `LSN_HDLC_MASK};
					end
				end
				`LSN_OFF_ETH_RANGE: begin
					next_prdata = {16'h0000, eth_range};
					if (pwrite) begin
						next_eth_range = pwdata[15:0] & {`LSN_ETH_MASK, `LSN_ETH_MASK};
					end
				end
				`LSN_OFF_STATUS: begin
					next_prdata = {tx_bytes, use_hdlc, use_eth, no_common, expired,
						startup_timer_running, link_state};
				end
				`LSN_OFF_RX_HELD: begin
					next_prdata = {7'h00, held_valid, held};
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	// Negotiation steps
	always_comb begin
		lsn_ctrl_bytes_t pick;
		logic            changed;
		logic            rate_match;
		pick               = tx_bytes;
		changed            = 1'b0;
		rate_match         = 1'b0;
		next_link_state    = link_state;
		next_tx_bytes      = tx_bytes;
		next_held          = held;
		next_held_valid    = held_valid;
		next_eval_cnt      = eval_tick ? 32'h0000_0000 : eval_cnt + 32'h0000_0001;
		next_timer_cnt     = startup_timer_running ? timer_cnt + 32'h0000_0001 : 32'h0000_0000;
		next_timer_running = startup_timer_running;
		next_use_eth       = 1'b0;
		next_use_hdlc      = 1'b0;
		next_restart_pulse = 1'b0;
		next_no_common     = no_common;
		// Software clears the expiry flag by writing one; a new expiry wins
		next_expired       = expired && !(apb_wr && paddr == `LSN_OFF_STATUS && pwdata[`LSN_STAT_EXPIRED]);

		if (eval_tick) begin
			changed         = !held_valid || (rx_clean != held); // R25
			next_held       = rx_clean; // R25
			next_held_valid = 1'b1;
		end

		unique case (link_state)
			LSN_IDLE: begin
				next_tx_bytes = '0;
				if (ctrl[`LSN_CTRL_ENABLE]) begin
					next_link_state = LSN_SYNC;
				end
			end
			LSN_SYNC: begin
				next_tx_bytes = {proto_range.hi, hdlc_range.hi, eth_range.hi};
				next_held_valid = 1'b0;
				if (hyperframe_sync_state) begin
					next_link_state    = LSN_PROTO;
					next_tx_bytes.proto = proto_range.hi; // R1
					next_timer_running = 1'b1;
					next_timer_cnt     = 32'h0000_0000;
					next_no_common     = 1'b0;
				end
			end
			LSN_PROTO: begin
				// Only the version byte is looked at here; layer one bits are not yet trusted
				if (eval_tick) begin // R6 R7
					if (rx_clean.proto == tx_bytes.proto) begin
						next_link_state = LSN_RATE; // R2 R5
					end else if (changed) begin
						pick.proto          = lsn_pick(rx_clean.proto, proto_range); // R3 R4
						next_tx_bytes.proto = pick.proto;
						if (rx_clean.proto == pick.proto) begin
							next_link_state = LSN_RATE; // R2 R5
						end
					end
				end
				if (next_link_state == LSN_RATE) begin
					next_tx_bytes.hdlc = hdlc_range.hi; // R8
					next_tx_bytes.eth  = eth_range.hi; // R8
					if (is_master && ctrl[`LSN_CTRL_CUST_PROP] && ctrl[`LSN_CTRL_CUST_KNOWN]) begin
						next_tx_bytes.hdlc = `LSN_HDLC_CUSTOM; // R13
					end
				end
			end
			LSN_RATE: begin
				if (eval_tick) begin
					if (rx_clean.proto != tx_bytes.proto) begin
						next_link_state = LSN_PROTO; // R15
					end else if (is_master && ctrl[`LSN_CTRL_NO_CM]) begin
						next_tx_bytes.hdlc = 8'h00; // R24
						next_tx_bytes.eth  = 8'h00;
						next_link_state    = LSN_PASSIVE;
						next_timer_running = 1'b0;
					end else if (!is_master && layer_one_passive) begin
						next_link_state    = LSN_PASSIVE; // R7 R21
						next_timer_running = 1'b0;
					end else begin
						rate_match = (rx_clean.hdlc == tx_bytes.hdlc && rx_clean.hdlc != 8'h00) ||
							(rx_clean.eth == tx_bytes.eth && rx_clean.eth != 8'h00);
						if (rate_match) begin
							next_link_state = LSN_IFNEG; // R9
						end else if (changed) begin
							pick.hdlc = lsn_pick_rate(rx_clean.hdlc, hdlc_range); // R10 R11 R12
							pick.eth  = lsn_pick_rate(rx_clean.eth, eth_range); // R10 R11 R12
							if (!is_master && rx_clean.hdlc == `LSN_HDLC_CUSTOM && ctrl[`LSN_CTRL_CUST_KNOWN]) begin
								pick.hdlc = `LSN_HDLC_CUSTOM; // R14
							end
							next_tx_bytes.hdlc = pick.hdlc;
							next_tx_bytes.eth  = pick.eth;
							if ((rx_clean.hdlc == pick.hdlc && pick.hdlc != 8'h00) ||
								(rx_clean.eth == pick.eth && pick.eth != 8'h00)) begin
								next_link_state = LSN_IFNEG; // R9
							end
						end
					end
				end
			end
			LSN_IFNEG: begin
				next_use_eth  = (held.eth == tx_bytes.eth) && (held.eth != 8'h00); // R17
				next_use_hdlc = !next_use_eth; // R17
				if (ctrl[`LSN_CTRL_CUST_NEGO]) begin
					next_tx_bytes.hdlc = `LSN_HDLC_CUSTOM; // R18
				end
				if (ctrl[`LSN_CTRL_CM_UP]) begin
					next_timer_running = 1'b0; // R19
				end
				if (held.proto != tx_bytes.proto) begin
					next_link_state    = LSN_PROTO; // R15
					next_timer_running = 1'b1;
				end else if (held.hdlc != tx_bytes.hdlc && held.eth != tx_bytes.eth) begin
					next_link_state    = LSN_RATE; // R16
					next_timer_running = 1'b1;
				end
			end
			LSN_PASSIVE: begin
				if (is_master) begin
					next_tx_bytes.hdlc = 8'h00;
					next_tx_bytes.eth  = 8'h00;
				end else begin
					next_tx_bytes.hdlc = hdlc_range.hi;
					next_tx_bytes.eth  = eth_range.hi;
				end
				if (held.proto != tx_bytes.proto) begin
					next_link_state    = LSN_PROTO;
					next_timer_running = 1'b1;
				end else if ((is_master && !ctrl[`LSN_CTRL_NO_CM]) || (!is_master && changed)) begin
					next_link_state    = LSN_RATE;
					next_tx_bytes.hdlc = hdlc_range.hi;
					next_tx_bytes.eth  = eth_range.hi;
					next_timer_running = 1'b1;
				end
			end
			default: begin
				next_link_state = LSN_IDLE;
			end
		endcase

		// Expiry restarts line synchronisation; silence in protocol setup on a master means no common version
		if (timer_expiry && next_timer_running) begin
			next_expired       = 1'b1;
			next_no_common     = no_common || (is_master && link_state == LSN_PROTO); // R20
			next_timer_running = 1'b0;
			next_restart_pulse = 1'b1;
			next_link_state    = LSN_SYNC;
		end
		if (link_state != LSN_IDLE && link_state != LSN_SYNC && !hyperframe_sync_state) begin
			next_link_state    = LSN_SYNC;
			next_timer_running = 1'b0;
		end
		if (!ctrl[`LSN_CTRL_ENABLE]) begin
			next_link_state    = LSN_IDLE;
			next_timer_running = 1'b0;
		end
		if (next_link_state != link_state) begin
			next_timer_cnt = 32'h0000_0000;
			// A setup step entered with already held bytes must still reselect once, or both ends wait forever
			if (next_link_state == LSN_PROTO || next_link_state == LSN_RATE) begin
				next_held_valid = 1'b0; // R25
			end
		end
		// Reserved bits leave as zero whatever software loaded
		next_tx_bytes.hdlc = next_tx_bytes.hdlc & `LSN_HDLC_MASK; // R23
		next_tx_bytes.eth  = next_tx_bytes.eth & `LSN_ETH_MASK; // R23
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl                  <= `LSN_CTRL_RESET;
			proto_range           <= `LSN_PROTO_RESET;
			hdlc_range            <= `LSN_HDLC_RESET;
			eth_range             <= `LSN_ETH_RESET;
			prdata                <= 32'h0000_0000;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
			expired               <= 1'b0;
			no_common             <= 1'b0;
			link_state            <= LSN_IDLE;
			tx_bytes              <= '0;
			held                  <= '0;
			held_valid            <= 1'b0;
			eval_cnt              <= 32'h0000_0000;
			timer_cnt             <= 32'h0000_0000;
			startup_timer_running <= 1'b0;
			use_eth               <= 1'b0;
			use_hdlc              <= 1'b0;
			restart_pulse         <= 1'b0;
		end else begin
			ctrl                  <= next_ctrl;
			proto_range           <= next_proto_range;
			hdlc_range            <= next_hdlc_range;
			eth_range             <= next_eth_range;
			prdata                <= next_prdata;
			pready                <= next_pready;
			pslverr               <= next_pslverr;
			expired               <= next_expired;
			no_common             <= next_no_common;
			link_state            <= next_link_state;
			tx_bytes              <= next_tx_bytes;
			held                  <= next_held;
			held_valid            <= next_held_valid;
			eval_cnt              <= next_eval_cnt;
			timer_cnt             <= next_timer_cnt;
			startup_timer_running <= next_timer_running;
			use_eth               <= next_use_eth;
			use_hdlc              <= next_use_hdlc;
			restart_pulse         <= next_restart_pulse;
		end
	end

endmodule : lsn_negotiator
`default_nettype wire

// >>> lsn_params.svh
// Register offsets, field positions, reset values and timing figures of the link start-up negotiator
`ifndef LSN_PARAMS_SVH
`define LSN_PARAMS_SVH

`define LSN_OFF_CTRL        8'h00
`define LSN_OFF_PROTO_RANGE 8'h04
`define LSN_OFF_HDLC_RANGE  8'h08
`define LSN_OFF_ETH_RANGE   8'h0c
`define LSN_OFF_STATUS      8'h10
`define LSN_OFF_RX_HELD     8'h14

`define LSN_CTRL_ENABLE     0
`define LSN_CTRL_MASTER     1
`define LSN_CTRL_CODING_64  2
`define LSN_CTRL_CUST_KNOWN 3
`define LSN_CTRL_CUST_PROP  4
`define LSN_CTRL_CM_UP      5
`define LSN_CTRL_CUST_NEGO  6
`define LSN_CTRL_NO_CM      7
`define LSN_CTRL_BITS       8

`define LSN_STAT_EXPIRED    4

`define LSN_CTRL_RESET      8'h00
`define LSN_PROTO_RESET     16'h0201
`define LSN_HDLC_RESET      16'h0601
`define LSN_ETH_RESET       16'h3f01

`define LSN_HDLC_MASK       8'h07
`define LSN_ETH_MASK        8'h3f
`define LSN_HDLC_CUSTOM     8'h07

`define LSN_CLK_HZ          50000000
`define LSN_EVAL_PERIOD_MS  100
`define LSN_STARTUP_MS      10000

`endif

// >>> lsn_pkg.sv
// Types shared by the link start-up negotiator
package lsn_pkg;

	typedef enum logic [2:0] {
		LSN_IDLE    = 3'b000,
		LSN_SYNC    = 3'b001,
		LSN_PROTO   = 3'b010,
		LSN_RATE    = 3'b011,
		LSN_IFNEG   = 3'b100,
		LSN_PASSIVE = 3'b101
	} lsn_state_t;

	typedef struct packed {
		logic [7:0] proto;
		logic [7:0] hdlc;
		logic [7:0] eth;
	} lsn_ctrl_bytes_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} lsn_range_t;

endpackage : lsn_pkg

// >>> lsn_assertions.sv
// Port checker of the link start-up negotiator
`timescale 1ns/100ps
`default_nettype none
module lsn_assertions
	import lsn_pkg::*;
#(
	parameter int unsigned EVAL_CYCLES = 8
) (
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic [7:0]      paddr,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire lsn_ctrl_bytes_t rx_bytes,
	input wire lsn_ctrl_bytes_t tx_bytes,
	input wire lsn_state_t      link_state,
	input wire logic            use_eth,
	input wire logic            use_hdlc,
	input wire logic            startup_timer_running,
	input wire logic            restart_pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Mismatch may wait for the next evaluation tick, plus decision latency
	localparam int LIMIT = EVAL_CYCLES + 3;
	int mis_cnt;
	int next_mis_cnt;
	always_comb begin
		next_mis_cnt = 0;
		if (link_state == LSN_IFNEG && rx_bytes.proto != tx_bytes.proto) begin
			next_mis_cnt = mis_cnt + 1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mis_cnt <= 0;
		end else begin
			mis_cnt <= next_mis_cnt;
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	AST_APB_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("pready not after exactly one wait state");
	AST_SLVERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_UNMAPPED: assert property ((s_setup and paddr > 8'h14) ##1 s_access |-> ##1 pslverr)
		else $error("unmapped access without pslverr");
	AST_RSV_ZERO: assert property (tx_bytes.hdlc[7:3] == 5'h0 && tx_bytes.eth[7:6] == 2'h0)
		else $error("reserved transmit bits set");
	AST_USE_ETH_ONLY: assert property (use_eth |-> !use_hdlc &&
		(link_state == LSN_IFNEG || $past(link_state) == LSN_IFNEG))
		else $error("channel choice outside negotiation or both chosen");
	AST_PASSIVE_TIMER: assert property (link_state == LSN_PASSIVE &&
		$past(link_state) == LSN_PASSIVE |-> !startup_timer_running)
		else $error("timer running in passive link");
	AST_EXPIRE_SYNC: assert property (restart_pulse |->
		link_state == LSN_SYNC || $past(link_state) == LSN_SYNC)
		else $error("expiry did not restart at sync");
	AST_PULSE_ONE: assert property (restart_pulse |=> !restart_pulse)
		else $error("restart pulse longer than one cycle");
	AST_IFNEG_PROTO: assert property (mis_cnt <= LIMIT)
		else $error("version mismatch not left in time");
endmodule : lsn_assertions

bind lsn_negotiator lsn_assertions #(
	.EVAL_CYCLES(EVAL_CYCLES)
) u_lsn_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .rx_bytes(rx_bytes), .tx_bytes(tx_bytes),
	.link_state(link_state), .use_eth(use_eth), .use_hdlc(use_hdlc),
	.startup_timer_running(startup_timer_running), .restart_pulse(restart_pulse)
);
`default_nettype wire

// >>> lsn_peer_model.sv
// Behavioural peer port at the far end of the link
`timescale 1ns/100ps
`default_nettype none
module lsn_peer_model
	import lsn_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            linked,
	input  wire lsn_range_t      proto_r,
	input  wire lsn_range_t      hdlc_r,
	input  wire lsn_range_t      eth_r,
	input  wire logic [7:0]      lag,
	input  wire logic            ovr_en,
	input  wire lsn_ctrl_bytes_t ovr,
	input  wire lsn_ctrl_bytes_t from_dut,
	output lsn_ctrl_bytes_t      to_dut
);
	lsn_ctrl_bytes_t cur;
	logic [7:0]      cnt;
	logic            rate_seen;
	function automatic logic [7:0] pick(input lsn_range_t r, input logic [7:0] x);
		if (x >= r.hi) return r.hi;
		return (x >= r.lo) ? x : r.lo;
	endfunction : pick
	// Zero rates mean the port is not in rate setup yet
	assign rate_seen = from_dut.hdlc[2:0] != 3'h0 || from_dut.eth[5:0] != 6'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
			cnt <= 8'h0;
		end else if (!linked) begin
			cur <= {proto_r.hi, hdlc_r.hi, eth_r.hi};
		end else if (cnt != 8'h0) begin
			cnt <= cnt - 8'h1;
		end else begin
			cnt <= lag;
			if (from_dut.proto != 8'h0 && from_dut.proto != cur.proto) begin
				cur.proto <= pick(proto_r, from_dut.proto);
			end
			if (rate_seen && from_dut.hdlc[2:0] != cur.hdlc[2:0] && from_dut.eth[5:0] != cur.eth[5:0]) begin
				cur.hdlc <= pick(hdlc_r, {5'h0, from_dut.hdlc[2:0]});
				cur.eth  <= pick(eth_r, {2'h0, from_dut.eth[5:0]});
			end
		end
	end
	// A released line shows the inverse of cur, which is reloaded with the highest range values one cycle after release
	assign to_dut = ovr_en ? ovr : (linked ? cur : ~cur);
endmodule : lsn_peer_model
`default_nettype wire

// >>> lsn_tb.sv
// Self-checking bench of the link start-up negotiator
`timescale 1ns/100ps
`default_nettype none
`include "lsn_params.svh"
module testbench;
	import lsn_pkg::*;
	localparam int EV = 8;
	logic            pclk = 1'b0;
	logic            presetn = 1'b0;
	logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sync = 1'b0, l1p = 1'b0, ovr_en = 1'b0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0, prdata;
	logic            pready, pslverr, use_eth, use_hdlc, tmr, rst_p;
	lsn_ctrl_bytes_t ovr = '0, rxb, txb;
	lsn_range_t      pr = 16'h0101, hr = 16'h0301, er = 16'h1001;
	lsn_state_t      st;
	int              fail_count = 0, n_tests = 0, pulses = 0;
	always #10 pclk = ~pclk;
	always @(posedge pclk) if (rst_p === 1'b1) pulses++;
	lsn_negotiator #(.EVAL_CYCLES(EV), .STARTUP_CYCLES(200)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hyperframe_sync_state(sync), .rx_bytes(rxb), .layer_one_passive(l1p), .tx_bytes(txb),
		.link_state(st), .use_eth(use_eth), .use_hdlc(use_hdlc), .startup_timer_running(tmr),
		.restart_pulse(rst_p));
	lsn_peer_model PEER (.pclk(pclk), .presetn(presetn), .linked(sync), .proto_r(pr), .hdlc_r(hr),
		.eth_r(er), .lag(8'd3), .ovr_en(ovr_en), .ovr(ovr), .from_dut(txb), .to_dut(rxb));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			fail_count++;
			$display("MISMATCH t=%0t no pready", $time);
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'(xe));
	endtask : rd
	task automatic wst(input lsn_state_t s);
		repeat (20 * EV) if (st !== s) @(posedge pclk);
		chk({29'h0, st}, {29'h0, s});
	endtask : wst
	// Every scenario starts from a fresh reset so earlier state cannot mask faults
	task automatic start(input logic [7:0] ctrl);
		@(posedge pclk);
		presetn <= 1'b0;
		sync    <= 1'b0;
		ovr_en  <= 1'b0;
		l1p     <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wr(`LSN_OFF_CTRL, {24'h0, ctrl});
		sync <= 1'b1;
	endtask : start
	task automatic t_regs;
		start(8'h00);
		rd(`LSN_OFF_PROTO_RANGE, 32'h0201, 1'b0);
		rd(`LSN_OFF_ETH_RANGE, 32'h3f01, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		wr(`LSN_OFF_HDLC_RANGE, 32'hff03);
		rd(`LSN_OFF_HDLC_RANGE, 32'h0703, 1'b0);
		chk({29'h0, st}, {29'h0, LSN_IDLE});
	endtask : t_regs
	task automatic t_master;
		start(8'h03);
		wst(LSN_PROTO);
		chk(32'(txb.proto), 32'h02);
		wst(LSN_RATE);
		chk(32'(txb.proto), 32'h01);
		chk(32'({txb.hdlc, txb.eth}), 32'h063f);
		wst(LSN_IFNEG);
		chk(32'({txb.hdlc, txb.eth}), 32'h0310);
		repeat (2) @(posedge pclk);
		chk(32'({use_eth, use_hdlc}), 32'h2);
		wr(`LSN_OFF_CTRL, 32'h43);
		repeat (3) @(posedge pclk);
		chk(32'(txb.hdlc), 32'h07);
		wr(`LSN_OFF_CTRL, 32'h63);
		repeat (3) @(posedge pclk);
		chk(32'(tmr), 32'h0);
		ovr    <= {8'h01, 8'h02, 8'h05};
		ovr_en <= 1'b1;
		wst(LSN_RATE);
		ovr_en <= 1'b0;
		wst(LSN_IFNEG);
		ovr    <= {8'h02, 8'h03, 8'h10};
		ovr_en <= 1'b1;
		wst(LSN_PROTO);
	endtask : t_master
	task automatic t_slave;
		pr <= 16'h0301;
		start(8'h01);
		wst(LSN_RATE);
		chk(32'(txb.proto), 32'h02);
		ovr    <= {8'h00, 8'hf8, 8'hc0};
		ovr_en <= 1'b1;
		wst(LSN_PROTO);
		repeat (3 * EV) @(posedge pclk);
		chk(32'(txb.proto), 32'h01);
		ovr <= {8'h01, 8'hf8, 8'hc0};
		wst(LSN_RATE);
		repeat (3 * EV) @(posedge pclk);
		chk(32'({txb.hdlc, txb.eth}), 32'h0101);
		l1p <= 1'b1;
		wst(LSN_PASSIVE);
	endtask : t_slave
	task automatic t_expire;
		logic [31:0] r;
		logic        e;
		start(8'h03);
		ovr    <= {8'h07, 8'h00, 8'h00};
		ovr_en <= 1'b1;
		pulses = 0;
		repeat (300) @(posedge pclk);
		chk(32'(pulses > 0), 32'h1);
		apb(1'b0, `LSN_OFF_STATUS, 32'h0, r, e);
		chk(32'(r[5:4]), 32'h1);
		wr(`LSN_OFF_STATUS, 32'h10);
		apb(1'b0, `LSN_OFF_STATUS, 32'h0, r, e);
		chk(32'(r[4]), 32'h0);
	endtask : t_expire
	task automatic t_nocm;
		start(8'h9b);
		wst(LSN_RATE);
		chk(32'(txb.hdlc), 32'h07);
		wst(LSN_PASSIVE);
		chk(32'({txb.hdlc, txb.eth}), 32'h0);
		chk(32'(tmr), 32'h0);
	endtask : t_nocm
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	initial begin
		t_regs();
		t_master();
		t_slave();
		t_nocm();
		t_expire();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		conclude();
	end
endmodule : testbench
`default_nettype wire
